// ---- hw/gzr_control.sv ----
`timescale 1ns/1ps
module gzr_control #(
    parameter logic [15:0] THRESHOLD = 16'h0400
) (
    input  wire logic                  clk_in,          // 50 MHz clock
    input  wire logic                  rst_n_in,        // async reset
    input  wire logic                  link_sclk_in,    // serial clock
    input  wire logic                  link_cs_n_in,    // frame select
    input  wire logic                  link_mosi_in,    // serial in
    output logic                       link_miso_out,   // serial out
    output logic                       link_miso_oe_n_out, // low drives
    input  wire logic                  vpwr_low_in,     // supply < 4.0 V
    input  wire logic                  vpwr_uv_in,      // undervoltage
    input  wire logic                  vpwr_ov_in,      // overvoltage
    input  wire logic                  clk_fault_in,    // clock off spec
    input  wire logic [1:0]            overheat_in,     // per gauge
    input  wire logic [1:0]            gauge_moving_in, // motion core
    input  wire logic [7:0]            coil_emf_in,     // sense sample
    output logic [1:0]                 gauge_enable_out, // drivers on
    output logic                       coil_angle_select_out, // 60 deg
    output logic                       zero_location_select_out, // cw
    output logic [11:0]                ramp_selection_out, // ramp cfg
    output gzr_pkg::gzr_poscmd_type    pos_cmd_out,     // position cmd
    output logic                       zero_active_out, // zeroing
    output logic                       zero_gauge_out,  // which gauge
    output logic [1:0]                 coil_drive_out,  // driven coil
    output logic                       sense_prep_out,  // prep sense
    output logic                       integrate_out,   // integrating
    output logic [11:0]                position0_out,   // gauge 0 pos
    output logic [11:0]                position1_out    // gauge 1 pos
);
    import gzr_pkg::*;

    // synchroniser bit positions
    localparam int SY_CS  = 0;
    localparam int SY_TOG = 1;
    localparam int SY_LOW = 2;
    localparam int SY_UV  = 3;
    localparam int SY_OV  = 4;
    localparam int SY_CLK = 5;
    localparam int SY_OT  = 6;

    typedef struct packed {
        logic [7:0]     sync1;
        logic [7:0]     sync2;
        logic           tog_seen;
        gzr_cfg_type    cfg;
        logic [11:0]    ramp;
        logic [1:0]     gen;
        logic           angle;
        logic           zloc;
        logic [1:0]     ot;
        logic           uv_a;
        logic           uv_b;
        logic           ov;
        logic           clk_bad;
        logic [15:0]    snap;
        gzr_seq_type    seq;
        logic           busy;
        logic           zg;
        logic           sdis;
        logic           dir;
        logic [1:0]     ok;
        logic [5:0]     tick_cnt;
        logic [15:0]    time_cnt;
        logic [15:0]    acc;
        logic           phase;
        logic [11:0]    pos0;
        logic [11:0]    pos1;
        gzr_poscmd_type pcmd;
    } gzr_state_type;

    localparam gzr_state_type ST_RESET = '{
        sync1: 8'h01, sync2: 8'h01, tog_seen: 1'b0, cfg: CFG_RESET,
        ramp: RAMP_RESET, gen: 2'h0, angle: 1'b0, zloc: 1'b0,
        ot: 2'h0, uv_a: 1'b1, uv_b: 1'b1, ov: 1'b0, clk_bad: 1'b0,
        snap: 16'h0000, seq: S_IDLE, busy: 1'b0, zg: 1'b0, sdis: 1'b0,
        dir: 1'b0, ok: 2'h0, tick_cnt: 6'h00, time_cnt: 16'h0000,
        acc: 16'h0000, phase: 1'b0, pos0: 12'h000, pos1: 12'h000,
        pcmd: '{valid: 1'b0, gauge: 1'b0, data: 12'h000}};

    // step period in time base ticks
    function automatic logic [15:0] step_ticks(input gzr_cfg_type c);
        logic [15:0] base;
        base = 16'((32'(c.fst) + 32'd1) * 32'(FST_UNIT_US));
        return base >> c.speed;
    endfunction

    // blanking time in time base ticks
    function automatic logic [15:0] blank_ticks(input gzr_cfg_type c);
        return c.blank_long ? 16'(BLANK_LONG_US) : 16'(BLANK_SHORT_US);
    endfunction

    // saturating accumulate of one sample
    function automatic logic [15:0] acc_add(input logic [15:0] a,
                                           input logic [7:0]  s);
        logic [16:0] sum;
        sum = {1'b0, a} + {9'h000, s};
        return sum[16] ? 16'hFFFF : sum[15:0];
    endfunction

    // ---------------- link domain ----------------
    logic [3:0]  lk_cnt;
    logic [14:0] lk_rx;
    logic [15:0] lk_word;
    logic        lk_tog;

    // the select doubles as the counter's reset, so a cut frame
    // leaves no stray bits behind for the next one
    // bit counter and shifter, cleared between frames by the select
    always_ff @(posedge link_sclk_in or posedge link_cs_n_in) begin
        if (link_cs_n_in) begin
            lk_cnt <= 4'h0;
            lk_rx  <= 15'h0000;
        end else begin
            lk_cnt <= lk_cnt + 4'h1;
            lk_rx  <= {lk_rx[13:0], link_mosi_in};
        end
    end

    // word held until the next 16th edge, long after the system side
    // has taken it, so only the toggle needs synchronising
    // a whole 16 bit word flips the toggle for the system side
    always_ff @(posedge link_sclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lk_word <= 16'h0000;
            lk_tog  <= 1'b0;
        end else if (!link_cs_n_in && lk_cnt == 4'hF) begin
            lk_word <= {lk_rx, link_mosi_in};
            lk_tog  <= ~lk_tog;
        end
    end

    gzr_state_type r;
    gzr_state_type next_r;

    // snap only rewritten while the synced select is high, so it
    // stands still for the whole frame on the serial clock side
    // status word out msb first; snapshot frozen during the frame
    assign link_miso_out      = r.snap[4'hF - lk_cnt];
    assign link_miso_oe_n_out = link_cs_n_in;

    // ---------------- system domain ----------------
    gzr_status_type status_now;
    logic           word_evt;
    logic           tick;
    logic [15:0]    w;
    logic [2:0]     code;
    logic [11:0]    delta;
    logic           g;
    logic [7:0]     pins;

    assign pins = {overheat_in, clk_fault_in, vpwr_ov_in, vpwr_uv_in,
                   vpwr_low_in, lk_tog, link_cs_n_in};
    assign w    = lk_word;
    assign code = w[CMD_LSB +: 3];
    assign g    = w[ZR_GAUGE_BIT];

    // live status view
    always_comb begin
        status_now.acc_hi  = r.acc[15:12];
        status_now.ok1     = r.ok[1];
        status_now.ok0     = r.ok[0];
        status_now.busy1   = r.busy & r.zg;
        status_now.busy0   = r.busy & ~r.zg;
        status_now.uv_b    = r.uv_b;
        status_now.uv_a    = r.uv_a;
        status_now.gauge1_moved_flag    = gauge_moving_in[1];
        status_now.gauge0_moved_flag    = gauge_moving_in[0];
        status_now.clk_bad = r.clk_bad;
        status_now.ov      = r.ov;
        status_now.ot1     = r.ot[1];
        status_now.ot0     = r.ot[0];
    end

    assign word_evt = r.sync2[SY_TOG] ^ r.tog_seen;
    assign tick     = r.tick_cnt == 6'(TICK_DIV - 1);
    assign delta    = r.angle ? (r.phase ? STEP_LONG : STEP_SHORT)
                              : STEP_EVEN;

    // next state
    always_comb begin
        next_r          = r;
        next_r.sync1    = pins;
        next_r.sync2    = r.sync1;
        next_r.tog_seen = r.sync2[SY_TOG];
        next_r.pcmd     = '{valid: 1'b0, gauge: 1'b0, data: 12'h000};
        next_r.tick_cnt = tick ? 6'h00 : r.tick_cnt + 6'h01;

        // a fault still present reasserts its flag in the same cycle,
        // so a status read never loses it
        // latched faults: a shifted flag clears, a live event wins
        next_r.uv_a    = (r.uv_a & ~(word_evt & r.snap[6]))
                       | r.sync2[SY_UV];
        next_r.uv_b    = (r.uv_b & ~(word_evt & r.snap[8]))
                       | r.sync2[SY_UV];
        next_r.ov      = (r.ov & ~(word_evt & r.snap[2]))
                       | r.sync2[SY_OV];
        next_r.clk_bad = (r.clk_bad & ~(word_evt & r.snap[3]))
                       | r.sync2[SY_CLK];

        // snapshot only when no frame is running or pending
        if (r.sync2[SY_CS] && !word_evt) begin
            next_r.snap = status_now;
        end

        // command decode
        if (word_evt) begin
            unique case (code)
                CMD_ZERO: begin
                    if (r.busy) begin
                        if (g == r.zg && !w[ZR_ENABLE_BIT]) begin
                            next_r.busy = 1'b0;
                            next_r.seq  = S_IDLE;
                        end
                    end else if (w[ZR_ENABLE_BIT]) begin
                        next_r.busy  = 1'b1;
                        next_r.zg    = g;
                        next_r.sdis  = w[ZR_SDIS_BIT];
                        next_r.dir   = w[ZR_DIR_BIT] ^ r.zloc;
                        next_r.ok[g] = 1'b0;
                        next_r.seq   = S_PREP;
                    end
                end
                CMD_CONFIG: begin
                    // config write also restarts the accumulator
                    next_r.cfg.fst        = w[CFG_FST_LSB +: 4];
                    next_r.cfg.blank_long = w[CFG_BLANK_BIT];
                    next_r.cfg.preload    = w[CFG_PRE_LSB +: 6];
                    next_r.cfg.speed      = w[CFG_SPD_LSB +: 2];
                    next_r.acc = {10'h000, w[CFG_PRE_LSB +: 6]};
                end
                CMD_ENABLE: begin
                    // the zeroing gauge keeps its enable
                    if (!(r.busy && !r.zg)) begin
                        next_r.gen[0] = w[EN_G0_BIT];
                        if (w[EN_G0_BIT] && !r.sync2[SY_OT]) begin
                            next_r.ot[0] = 1'b0;
                        end
                    end
                    if (!(r.busy && r.zg)) begin
                        next_r.gen[1] = w[EN_G1_BIT];
                        if (w[EN_G1_BIT] && !r.sync2[SY_OT + 1]) begin
                            next_r.ot[1] = 1'b0;
                        end
                    end
                    if (!r.busy) begin
                        next_r.angle = w[EN_ANGLE_BIT];
                        next_r.zloc  = w[EN_ZLOC_BIT];
                    end
                end
                CMD_POS0, CMD_POS1: begin
                    if (!(r.busy && r.zg == code[0])) begin
                        next_r.pcmd.valid = 1'b1;
                        next_r.pcmd.gauge = code[0];
                        next_r.pcmd.data  = w[11:0];
                    end
                end
                CMD_RAMP: begin
                    next_r.ramp = w[11:0];
                end
                default: begin
                end
            endcase
        end

        // zeroing sequencer
        unique case (r.seq)
            S_IDLE: begin
            end
            // phase is carried over between events, so a new event
            // continues the step spacing where the last one left off
            S_PREP: begin
                next_r.phase    = ~r.phase;
                next_r.acc      = {10'h000, r.cfg.preload};
                next_r.time_cnt = 16'h0000;
                next_r.seq      = S_BLANK;
                if (r.zg) begin
                    next_r.pos1 = r.dir ? r.pos1 + delta
                                        : r.pos1 - delta;
                end else begin
                    next_r.pos0 = r.dir ? r.pos0 + delta
                                        : r.pos0 - delta;
                end
            end
            S_BLANK: begin
                if (tick) begin
                    next_r.time_cnt = r.time_cnt + 16'h0001;
                    if (r.time_cnt + 16'h0001 >= blank_ticks(r.cfg)) begin
                        next_r.seq = S_INTEG;
                    end
                end
            end
            S_INTEG: begin
                if (tick) begin
                    next_r.time_cnt = r.time_cnt + 16'h0001;
                    next_r.acc      = acc_add(r.acc, coil_emf_in);
                    if (r.time_cnt + 16'h0001 >= step_ticks(r.cfg)) begin
                        next_r.seq = S_DECIDE;
                    end
                end
            end
            S_DECIDE: begin
                if (r.acc > THRESHOLD || r.sdis) begin
                    next_r.seq = S_PREP;
                end else begin
                    next_r.seq      = S_IDLE;
                    next_r.busy     = 1'b0;
                    next_r.ok[r.zg] = 1'b1;
                    if (r.zg) begin
                        next_r.pos1 = 12'h000;
                    end else begin
                        next_r.pos0 = 12'h000;
                    end
                end
            end
            default: begin
                next_r.seq = S_IDLE;
            end
        endcase

        // after decode, so a same-cycle enable write cannot win
        // overheat: latch and shut the gauge off
        for (int i = 0; i < 2; i++) begin
            if (r.sync2[SY_OT + i]) begin
                next_r.ot[i]  = 1'b1;
                next_r.gen[i] = 1'b0;
            end
        end

        // zeroing dropped too: pointer position no longer trusted
        // motor supply below 4.0 V restores defaults
        if (r.sync2[SY_LOW]) begin
            next_r.cfg   = CFG_RESET;
            next_r.ramp  = RAMP_RESET;
            next_r.gen   = 2'h0;
            next_r.angle = 1'b0;
            next_r.zloc  = 1'b0;
            next_r.busy  = 1'b0;
            next_r.seq   = S_IDLE;
            next_r.uv_a  = 1'b1;
            next_r.uv_b  = 1'b1;
        end
    end

    // pin low holds every field at its default
    // state register, pin reset to defaults
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= ST_RESET;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign gauge_enable_out         = r.gen;
    assign coil_angle_select_out    = r.angle;
    assign zero_location_select_out = r.zloc;
    assign ramp_selection_out       = r.ramp;
    assign pos_cmd_out              = r.pcmd;
    assign zero_active_out          = r.busy;
    assign zero_gauge_out           = r.zg;
    // both coils off in the prep cycle while the sense coil settles
    assign coil_drive_out = (r.busy && r.seq != S_PREP)
                          ? (r.phase ? 2'b10 : 2'b01) : 2'b00;
    assign sense_prep_out  = r.seq == S_PREP;
    assign integrate_out   = r.seq == S_INTEG;
    assign position0_out   = r.pos0;
    assign position1_out   = r.pos1;
endmodule

// ---- hw/gzr_pkg.sv ----
// Behaviour
// - zero command with shutdown-disable 0 runs automatic zeroing ending on stall
// - zero command with shutdown-disable 1 runs zeroing that stall never ends
// - commands for the zeroing gauge are ignored until success or abort
// - status word shows zeroing in progress once an event starts
// - stall detected reports success and frees the gauge for commands
// - config preload field is loaded into the accumulator as start offset
// - zero location 0 steps counterclockwise in full steps at configured rate
// - one coil driven per full step, the other coil senses motion
// - each step: prepare sense coil, blank, then integrate rest of step
// - accumulator above threshold means moving, else stop if shutdown enabled
// - shutdown-disable 1 keeps stepping until the host clears enable
// - zero request while other gauge zeroes is ignored, other stays usable
// - success sets the gauge position so the end stop becomes step zero
// - coil angle bit set alternates step spacing four and eight, else six
// - after reset config reads as zero except step time and ramp defaults
// - after reset coils are disabled and both undervoltage flags are set
// - reset on supply power-up, motor supply below 4.0 V, or reset pin
// - supply and clock flags stay latched until shifted out
// - overheat disables the gauge; flag clears on re-enable when cool
// - overvoltage is detected with gauges enabled or disabled
// - zero command bits: gauge select, event enable, direction select
package gzr_pkg;
    // time base
    localparam int CLK_HZ        = 50_000_000;
    localparam int TIME_BASE_HZ  = 1_000_000;
    localparam int TICK_DIV      = CLK_HZ / TIME_BASE_HZ;
    localparam int FST_UNIT_US   = 256;
    localparam int BLANK_SHORT_US = 384;
    localparam int BLANK_LONG_US = 768;
    // command codes in word bits 15:13
    localparam logic [2:0] CMD_ENABLE = 3'h1;
    localparam logic [2:0] CMD_ZERO   = 3'h2;
    localparam logic [2:0] CMD_CONFIG = 3'h3;
    localparam logic [2:0] CMD_POS0   = 3'h4;
    localparam logic [2:0] CMD_POS1   = 3'h5;
    localparam logic [2:0] CMD_RAMP   = 3'h6;
    localparam int CMD_LSB = 13;
    // zero_return_command fields
    localparam int ZR_GAUGE_BIT  = 0;
    localparam int ZR_ENABLE_BIT = 1;
    localparam int ZR_DIR_BIT    = 2;
    localparam int ZR_SDIS_BIT   = 4;
    // zero_return_config_command fields
    localparam int CFG_FST_LSB   = 0;
    localparam int CFG_BLANK_BIT = 4;
    localparam int CFG_PRE_LSB   = 5;
    localparam int CFG_SPD_LSB   = 11;
    // enable command fields
    localparam int EN_G0_BIT     = 0;
    localparam int EN_G1_BIT     = 1;
    localparam int EN_ANGLE_BIT  = 6;
    localparam int EN_ZLOC_BIT   = 7;
    // reset values
    localparam logic [3:0]  FST_RESET  = 4'h8;
    localparam logic [11:0] RAMP_RESET = 12'h000;
    // step spacing in microsteps
    localparam logic [11:0] STEP_EVEN  = 12'h006;
    localparam logic [11:0] STEP_SHORT = 12'h004;
    localparam logic [11:0] STEP_LONG  = 12'h008;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_PREP   = 3'b001,
        S_BLANK  = 3'b010,
        S_INTEG  = 3'b011,
        S_DECIDE = 3'b100
    } gzr_seq_type;

    typedef struct packed {
        logic [1:0] speed;
        logic [5:0] preload;
        logic       blank_long;
        logic [3:0] fst;
    } gzr_cfg_type;

    typedef struct packed {
        logic [3:0] acc_hi;
        logic       ok1;
        logic       ok0;
        logic       busy1;
        logic       uv_b;
        logic       busy0;
        logic       uv_a;
        logic       gauge1_moved_flag;
        logic       gauge0_moved_flag;
        logic       clk_bad;
        logic       ov;
        logic       ot1;
        logic       ot0;
    } gzr_status_type;

    typedef struct packed {
        logic        valid;
        logic        gauge;
        logic [11:0] data;
    } gzr_poscmd_type;

    localparam gzr_cfg_type CFG_RESET = '{
        speed: 2'h0, preload: 6'h00, blank_long: 1'b0, fst: FST_RESET};
endpackage

// ---- dv/gzr_control_sva.sv ----
`timescale 1ns/1ps
module gzr_control_sva
    import gzr_pkg::*;
(
    input wire logic           clk_in,             // clock
    input wire logic           rst_n_in,           // reset
    input wire logic [1:0]     gauge_enable_out,   // drivers on
    input wire logic [11:0]    ramp_selection_out, // ramp cfg
    input wire logic           zero_active_out,    // zeroing
    input wire logic           zero_gauge_out,     // which gauge
    input wire logic [1:0]     coil_drive_out,     // driven coil
    input wire logic           sense_prep_out,     // prep sense
    input wire logic           integrate_out       // integrating
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // blanking keeps integration off after each prep
    sequence s_blank;
        !integrate_out [*8];
    endsequence
    // decision leads to next prep or to idle
    sequence s_decide;
        ##[1:2] (sense_prep_out || !zero_active_out);
    endsequence

    AST_COIL_ONE: assert property (zero_active_out && !sense_prep_out
        |-> $onehot(coil_drive_out)) else $error("two or no coils driven");
    AST_COIL_IDLE: assert property (!zero_active_out
        |-> coil_drive_out == 2'h0) else $error("coil driven when idle");
    AST_PREP_PULSE: assert property (sense_prep_out |=> !sense_prep_out)
        else $error("prep longer than one cycle");
    AST_BLANK: assert property (sense_prep_out |=> s_blank)
        else $error("integration without blanking");
    AST_INTEG_ZERO: assert property (integrate_out
        |-> zero_active_out && !sense_prep_out)
        else $error("integration outside zeroing");
    AST_DECIDE: assert property ($fell(integrate_out) |-> s_decide)
        else $error("no decision after integration");
    AST_GAUGE_HOLD: assert property (zero_active_out &&
        $past(zero_active_out) |-> $stable(zero_gauge_out))
        else $error("zeroing gauge changed mid event");
    AST_RESET_DEF: assert property ($rose(rst_n_in) |->
        gauge_enable_out == 2'h0 && ramp_selection_out == 12'h000)
        else $error("defaults wrong after reset");
endmodule

bind gzr_control gzr_control_sva i_gzr_control_sva (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .gauge_enable_out(gauge_enable_out),
    .ramp_selection_out(ramp_selection_out),
    .zero_active_out(zero_active_out), .zero_gauge_out(zero_gauge_out),
    .coil_drive_out(coil_drive_out), .sense_prep_out(sense_prep_out),
    .integrate_out(integrate_out));

// ---- dv/gzr_host.sv ----
`timescale 1ns/1ps
module gzr_host (
    output logic           sclk_out, // serial clock, still between frames
    output logic           cs_n_out, // frame select
    output logic           mosi_out, // serial out to device
    input  wire logic      miso_in   // status in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // one 16 bit frame, msb first, 160 ns serial period
    task automatic xfer(input logic [15:0] word, output logic [15:0] stat);
        #37;
        cs_n_out = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_out = word[i];
            #80;
            stat[i] = miso_in;
            sclk_out = 1'b1;
            #80;
            sclk_out = 1'b0;
        end
        #80;
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // released line shows no stale data
        #400;
    endtask
endmodule

// ---- dv/gzr_control_tb.sv ----
`timescale 1ns/1ps
module gzr_control_tb;
    import gzr_pkg::*;
    logic clk_in, rst_n_in, sclk, cs_n, mosi, miso;
    logic vpwr_low_in, vpwr_uv_in, vpwr_ov_in, clk_fault_in;
    logic [1:0] overheat_in, gauge_moving_in, gauge_enable_out, coil_drive;
    logic [7:0] coil_emf_in, emf_mask;
    logic [11:0] ramp_sel, pos0, pos1, pa;
    logic zero_active, zero_gauge, angle, zloc, oe_n;
    logic [15:0] st;
    logic [31:0] rnd;
    gzr_poscmd_type pcmd;
    gzr_poscmd_type pq[$];
    int mismatches, compares;
    int seed = 32'h241a;

    gzr_control i_gzr_control (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .link_sclk_in(sclk), .link_cs_n_in(cs_n), .link_mosi_in(mosi),
        .link_miso_out(miso), .link_miso_oe_n_out(oe_n),
        .vpwr_low_in(vpwr_low_in), .vpwr_uv_in(vpwr_uv_in),
        .vpwr_ov_in(vpwr_ov_in), .clk_fault_in(clk_fault_in),
        .overheat_in(overheat_in), .gauge_moving_in(gauge_moving_in),
        .coil_emf_in(coil_emf_in), .gauge_enable_out(gauge_enable_out),
        .coil_angle_select_out(angle), .zero_location_select_out(zloc),
        .ramp_selection_out(ramp_sel), .pos_cmd_out(pcmd),
        .zero_active_out(zero_active), .zero_gauge_out(zero_gauge),
        .coil_drive_out(coil_drive), .sense_prep_out(), .integrate_out(),
        .position0_out(pos0), .position1_out(pos1));
    gzr_host i_gzr_host (.sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi), .miso_in(miso));

    always #10 clk_in = ~clk_in;
    // random motion flags and sense samples
    always @(posedge clk_in) begin
        #1;
        rnd = $random(seed);
        gauge_moving_in = rnd[1:0];
        coil_emf_in = rnd[15:8] & emf_mask;
    end
    task check(input string name, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task finish_test;
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // position command watcher against queued notes
    always @(posedge clk_in) begin
        if (pcmd.valid === 1'b1) begin
            if (pq.size() == 0) begin
                mismatches++;
                $display("CHECK FAILED pos_cmd expected none seen %h", pcmd);
            end else begin
                check("pos_cmd", {3'h0, pcmd.gauge, pcmd.data},
                    {3'h0, pq[0].gauge, pq[0].data});
                void'(pq.pop_front());
            end
        end
    end
    task send(input logic [15:0] word);
        i_gzr_host.xfer(word, st);
        @(posedge clk_in);
        #1;
    endtask
    // wait for prep pulse (0) or for zeroing to end (1)
    task wait_for(input int which, input int lim);
        int n;
        n = 0;
        while (n < lim && !(which == 0
            ? i_gzr_control.sense_prep_out === 1'b1 : zero_active === 1'b0))
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n == lim) begin
            mismatches++;
            finish_test;
        end
    endtask

    initial begin
        clk_in = 1'b0;
        rst_n_in = 1'b0;
        {vpwr_low_in, vpwr_uv_in, vpwr_ov_in, clk_fault_in} = 4'h0;
        overheat_in = 2'h0;
        gauge_moving_in = 2'h0;
        coil_emf_in = 8'h00;
        emf_mask = 8'h1F;
        repeat (6) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        check("enable", {14'h0, gauge_enable_out}, 16'h0000);
        check("ramp", {4'h0, ramp_sel}, 16'h0000);
        send(16'h0000);
        check("uv_set", st & 16'h0140, 16'h0140);
        send(16'h0000);
        check("uv_clear", st & 16'h0140, 16'h0000);
        vpwr_ov_in = 1'b1;
        repeat (5) @(posedge clk_in);
        #1 vpwr_ov_in = 1'b0;
        send(16'h0000);
        check("ov_set", st & 16'h0004, 16'h0004);
        send(16'h0000);
        check("ov_clear", st & 16'h0004, 16'h0000);
        send(16'h7800); // fastest step, zero preload
        send(16'h2003);
        check("enable", {14'h0, gauge_enable_out}, 16'h0003);
        pq.push_back('{1'b1, 1'b0, 12'h00C});
        send(16'h800C); // pointer 12 microsteps clockwise first
        send(16'h4002); // automatic zeroing of gauge 0
        check("zero_g0", {14'h0, zero_active, zero_gauge}, 16'h0002);
        check("ccw_step", {4'h0, pos0}, 16'h0FFA);
        send(16'h0000);
        check("busy0", st & 16'h0480, 16'h0080);
        send(16'h8123); // ignored while zeroing
        send(16'h4003);
        check("refuse_g1", {15'h0, zero_gauge}, 16'h0000);
        pq.push_back('{1'b1, 1'b1, 12'h456});
        send(16'hA456);
        wait_for(1, 30000);
        check("pos0_zero", {4'h0, pos0}, 16'h0000);
        send(16'h0000);
        check("ok0", st & 16'h0480, 16'h0400);
        emf_mask = 8'hFF;
        send(16'h2043); // coil angle set
        check("angle", {15'h0, angle}, 16'h0001);
        send(16'h4013); // unconditional zeroing of gauge 1
        check("zero_g1", {14'h0, zero_active, zero_gauge}, 16'h0003);
        pa = pos1;
        wait_for(0, 30000);
        @(posedge clk_in);
        #1;
        check("step_12", {4'h0, 12'h000 - pos1}, 16'h000C);
        check("step_alt", {15'h0, (pa - pos1) == 12'h004
            || (pa - pos1) == 12'h008}, 16'h0001);
        send(16'h4011); // abort
        check("abort", {15'h0, zero_active}, 16'h0000);
        send(16'h0000);
        check("ok1", st & 16'h0A00, 16'h0000);
        overheat_in = 2'h1;
        repeat (5) @(posedge clk_in);
        #1 overheat_in = 2'h0;
        check("ot_off", {14'h0, gauge_enable_out}, 16'h0002);
        send(16'h0000);
        check("ot_set", st & 16'h0003, 16'h0001);
        send(16'h2083); // re-enable, zero location 1
        send(16'h0000);
        check("ot_clear", st & 16'h0003, 16'h0000);
        check("zloc", {15'h0, zloc}, 16'h0001);
        send(16'hC0A5);
        check("ramp_set", {4'h0, ramp_sel}, 16'h00A5);
        {vpwr_low_in, clk_fault_in} = 2'h3;
        repeat (5) @(posedge clk_in);
        #1 {vpwr_low_in, clk_fault_in} = 2'h0;
        check("low_def", {1'b0, zloc, gauge_enable_out, ramp_sel},
            16'h0000);
        send(16'h0000);
        check("low_flags", st & 16'h0148, 16'h0148);
        check("oe_idle", {15'h0, oe_n}, 16'h0001);
        check("pq_empty", 16'(pq.size()), 16'h0000);
        finish_test;
    end
endmodule
